// >>> standby_halt_stop_control.sv
// standby sequencer: halt/stop entry, release, stabilisation wait, pin hold
// assumes cpu decode and interrupt controller on clk_in; osc start is an async pin
// Functional notes
// [RQ1] halt instruction enters halt on either clock
// [RQ2] halt gates cpu clock, oscillators keep running
// [RQ3] stop instruction halts main oscillator
// [RQ4] stop only on main clock; subclock never stopped
// [RQ5] registers, latches and buffers hold during standby
// [RQ6] select codes 0..4 give 2^12..2^17 waits
// [RQ7] select register byte-written, resets to 04H
// [RQ8] wait counts only after oscillator has started
// [RQ9] watch timer runs only on subsystem clock
// [RQ10] 16-bit timer runs only on external input; code gates it so in main-clock halt only, in subclock halt it always runs
// [RQ11] serial runs only with external serial clock
// [RQ12] bus pins float, hold, strobes parked in halt
// [RQ13] unmasked interrupt ends halt, vector or continue
// [RQ14] wake delay 8 clocks vectored, 2 otherwise
// [RQ15] nmi ends halt and always vectors
// [RQ16] reset ends halt, restart from reset vector
// [RQ17] interrupt ends stop after stabilisation wait
// [RQ18] pending interrupt at stop falls back to halt
`timescale 1ns/10ps
module standby_halt_stop_control
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // register port
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [7:0]       rdata_out,
    // cpu instruction decode
    input  wire logic        halt_exec_in,
    input  wire logic        stop_exec_in,
    input  wire logic        on_subclock_in,
    // interrupt controller
    input  wire logic        irq_unmasked_in,
    input  wire logic        irq_ack_enable_in,
    input  wire logic        nmi_in,
    // clock generator
    input  wire logic        main_osc_started_in,
    output logic             main_osc_enable_out,
    output logic             cpu_clk_enable_out,
    // resume control to cpu
    output logic             resume_vector_out,
    output logic             resume_next_out,
    output logic             reset_vector_out,
    output logic             hold_state_out,
    // peripheral run permissions
    output logic             watch_timer_run_out,
    output logic             timer16_run_out,
    output logic             serial_run_out,
    // external bus pins during expansion
    output logic             bus_hold_out,
    output logic             muxed_addr_data_lines_oe_out,
    output logic             address_strobe_out,
    output logic             rd_strobe_n_out,
    output logic             wr_strobe_n_out,
    output logic             wait_pin_oe_out,
    // status
    output logic [4:0]       state_out
);
    // state is declared ahead of the register file, which reads it back as status
    standby_pkg::stby_state_t state_ff, nxt_state;  // sequencer state
    stby_regs_if regs_bus ();  // register values to this sequencer

    // decode of select code to wait length, used by two places
    function automatic logic [standby_pkg::CNT_W-1:0] stab_len(input logic [2:0] code);
        logic [standby_pkg::CNT_W-1:0] one;
        one = {{(standby_pkg::CNT_W-1){1'b0}}, 1'b1};
        unique case (code)
            3'h0:    stab_len = one << standby_pkg::EXP_C0; // [RQ6]
            3'h1:    stab_len = one << standby_pkg::EXP_C1;
            3'h2:    stab_len = one << standby_pkg::EXP_C2;
            3'h3:    stab_len = one << standby_pkg::EXP_C3;
            default: stab_len = one << standby_pkg::EXP_C4;  // prohibited codes never stored
        endcase
    endfunction

    // register file
    stby_regfile u_regs
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .addr_in   (addr_in),
        .wdata_in  (wdata_in),
        .wr_in     (wr_in),
        .rd_in     (rd_in),
        .rdata_out (rdata_out),
        .state_in  (state_ff),
        .regs      (regs_bus.regs)
    );

    // oscillator start pin crosses into clk_in by two flops
    logic osc_sync1_ff;  // first stage, read only by second
    logic osc_sync2_ff;  // usable level
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            osc_sync1_ff <= 1'b0;
            osc_sync2_ff <= 1'b0;
        end
        else
        begin
            osc_sync1_ff <= main_osc_started_in;
            osc_sync2_ff <= osc_sync1_ff;
        end
    end

    logic [standby_pkg::CNT_W-1:0]  cnt_ff, nxt_cnt;         // wait counter
    logic                           vec_ff, nxt_vec;         // resume will vector
    logic                           sub_ff, nxt_sub;         // halted on subclock
    logic                           rstwake_ff, nxt_rstwake; // wake after reset
    logic                           vec_p, next_p, rv_p;     // resume pulses

    // next-state logic
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_vec     = vec_ff;
        nxt_sub     = sub_ff;
        nxt_rstwake = rstwake_ff;
        vec_p       = 1'b0;
        next_p      = 1'b0;
        rv_p        = 1'b0;
        unique case (state_ff)
            standby_pkg::ST_RUN:
            begin
                if (stop_exec_in && !on_subclock_in) // [RQ4]
                begin
                    if (irq_unmasked_in || nmi_in)
                    begin
                        // pending request: fall back to halt, still wait for stabilisation
                        nxt_state = standby_pkg::ST_STAB; // [RQ18]
                        nxt_cnt   = stab_len(regs_bus.stab_sel);
                        nxt_vec   = irq_ack_enable_in || nmi_in;
                    end
                    else
                        nxt_state = standby_pkg::ST_STOP; // [RQ3]
                end
                else if (halt_exec_in)
                begin
                    nxt_state = standby_pkg::ST_HALT; // [RQ1]
                    nxt_sub   = on_subclock_in;
                end
            end
            standby_pkg::ST_HALT:
            begin
                if (nmi_in)
                begin
                    nxt_state = standby_pkg::ST_WAKE; // [RQ15]
                    nxt_vec   = 1'b1;
                    nxt_cnt   = {{(standby_pkg::CNT_W-4){1'b0}}, standby_pkg::WAKE_VECTOR_CLKS};
                end
                else if (irq_unmasked_in)
                begin
                    nxt_state = standby_pkg::ST_WAKE; // [RQ13]
                    nxt_vec   = irq_ack_enable_in;
                    nxt_cnt   = irq_ack_enable_in ? // [RQ14]
                        {{(standby_pkg::CNT_W-4){1'b0}}, standby_pkg::WAKE_VECTOR_CLKS} :
                        {{(standby_pkg::CNT_W-4){1'b0}}, standby_pkg::WAKE_NEXT_CLKS};
                end
            end
            standby_pkg::ST_STOP:
            begin
                // nmi is not a stop release source; only unmasked maskable requests
                if (irq_unmasked_in)
                begin
                    nxt_state = standby_pkg::ST_STAB; // [RQ17]
                    nxt_vec   = irq_ack_enable_in;
                    nxt_cnt   = stab_len(regs_bus.stab_sel);
                end
            end
            standby_pkg::ST_STAB:
            begin
                // count only once the oscillator reports running
                if (osc_sync2_ff) // [RQ8]
                begin
                    if (cnt_ff == {standby_pkg::CNT_W{1'b0}})
                    begin
                        nxt_state   = standby_pkg::ST_RUN;
                        nxt_rstwake = 1'b0;
                        rv_p        = rstwake_ff; // [RQ16]
                        vec_p       = !rstwake_ff && vec_ff; // [RQ17]
                        next_p      = !rstwake_ff && !vec_ff;
                    end
                    else
                        nxt_cnt = cnt_ff - {{(standby_pkg::CNT_W-1){1'b0}}, 1'b1};
                end
            end
            standby_pkg::ST_WAKE:
            begin
                // fixed wake delay before the cpu resumes
                if (cnt_ff == {{(standby_pkg::CNT_W-1){1'b0}}, 1'b1})
                begin
                    nxt_state = standby_pkg::ST_RUN; // [RQ14]
                    vec_p     = vec_ff;
                    next_p    = !vec_ff;
                end
                nxt_cnt = cnt_ff - {{(standby_pkg::CNT_W-1){1'b0}}, 1'b1};
            end
            default:
                nxt_state = standby_pkg::ST_RUN;  // illegal code recovers to run
        endcase
    end

    // state registers; reset forces the post-reset stabilisation
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_ff   <= standby_pkg::ST_STAB; // [RQ16]
            cnt_ff     <= {1'b1, {(standby_pkg::CNT_W-1){1'b0}}};  // 2^17, reset code
            vec_ff     <= 1'b0;
            sub_ff     <= 1'b0;
            rstwake_ff <= 1'b1;
        end
        else
        begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            vec_ff     <= nxt_vec;
            sub_ff     <= nxt_sub;
            rstwake_ff <= nxt_rstwake;
        end
    end

    // registered outputs
    logic vec_o_ff, next_o_ff, rv_o_ff;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            vec_o_ff  <= 1'b0;
            next_o_ff <= 1'b0;
            rv_o_ff   <= 1'b0;
        end
        else
        begin
            vec_o_ff  <= vec_p;
            next_o_ff <= next_p;
            rv_o_ff   <= rv_p;
        end
    end

    logic standby;  // any standby state
    logic halted_sub;
    logic expand;
    assign standby    = state_ff != standby_pkg::ST_RUN;
    assign halted_sub = (state_ff == standby_pkg::ST_HALT) && sub_ff;
    assign expand     = regs_bus.ctrl[standby_pkg::CTRL_EXPAND_BIT];

    // clocks: main oscillator off only in stop; subclock untouched
    assign main_osc_enable_out = state_ff != standby_pkg::ST_STOP; // [RQ3] [RQ4]
    assign cpu_clk_enable_out  = !standby; // [RQ2]
    assign hold_state_out      = standby; // [RQ5]
    assign resume_vector_out   = vec_o_ff;
    assign resume_next_out     = next_o_ff;
    assign reset_vector_out    = rv_o_ff;
    assign state_out           = state_ff;

    // peripheral permissions while standby
    assign watch_timer_run_out = !halted_sub || regs_bus.ctrl[standby_pkg::CTRL_WT_SUB_BIT]; // [RQ9]
    assign timer16_run_out     = (state_ff != standby_pkg::ST_HALT) || sub_ff ||
                                 regs_bus.ctrl[standby_pkg::CTRL_T16_EXT_BIT]; // [RQ10]
    assign serial_run_out      = !halted_sub || regs_bus.ctrl[standby_pkg::CTRL_SIO_EXT_BIT]; // [RQ11]

    // bus pins parked while in standby with expansion on
    assign bus_hold_out                 = standby && expand; // [RQ12]
    assign muxed_addr_data_lines_oe_out = expand && !standby;
    assign address_strobe_out           = 1'b0;
    assign rd_strobe_n_out              = 1'b1;
    assign wr_strobe_n_out              = 1'b1;
    assign wait_pin_oe_out              = 1'b0;

    // halt entry gates the cpu clock next cycle
    a_halt_entry: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_RUN && halt_exec_in && !stop_exec_in)
        |=> !cpu_clk_enable_out && main_osc_enable_out) // [RQ1]
        else $error("halt entry failed");

    a_stop_osc_off: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_RUN && stop_exec_in && !on_subclock_in && !irq_unmasked_in && !nmi_in)
        |=> !main_osc_enable_out) // [RQ3]
        else $error("stop did not halt oscillator");

    a_stop_sub_blocked: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_RUN && stop_exec_in && on_subclock_in && !halt_exec_in)
        |=> main_osc_enable_out && state_ff == standby_pkg::ST_RUN) // [RQ4]
        else $error("stop taken on subclock");

    a_wait_needs_osc: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_STAB && !osc_sync2_ff) |=> $stable(cnt_ff)) // [RQ8]
        else $error("wait counted before oscillator start");

    // resume pulses are registered, so they show one edge after the last wake cycle
    a_halt_vector_wake: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_HALT && irq_unmasked_in && irq_ack_enable_in)
        |-> ##9 resume_vector_out) // [RQ14]
        else $error("vectored wake not after 8 clocks");

    a_halt_next_wake: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_HALT && irq_unmasked_in && !irq_ack_enable_in && !nmi_in)
        |-> ##3 resume_next_out) // [RQ13]
        else $error("continue wake not after 2 clocks");

    a_nmi_vectors: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_HALT && nmi_in) |-> ##9 resume_vector_out) // [RQ15]
        else $error("nmi did not vector");

    a_stop_pending: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == standby_pkg::ST_RUN && stop_exec_in && !on_subclock_in && irq_unmasked_in)
        |=> state_ff == standby_pkg::ST_STAB && main_osc_enable_out) // [RQ18]
        else $error("pending request did not fall back");

    a_bus_parked: assert property (@(posedge clk_in) disable iff (rst_in)
        (hold_state_out && expand) |-> !muxed_addr_data_lines_oe_out && bus_hold_out) // [RQ12]
        else $error("bus not parked in standby");
endmodule // standby_halt_stop_control

// >>> standby_pkg.sv
// package for the standby controller: register map, field layout, timing constants
// assumes a single 100 MHz clock domain
package standby_pkg;
    localparam logic [15:0] OSC_STAB_SEL_ADDR  = 16'hFFFA;  // select register address
    localparam logic [15:0] STBY_CTRL_ADDR     = 16'hFFF0;  // control/strap register
    localparam logic [15:0] STBY_STATUS_ADDR   = 16'hFFF1;  // state readback
    localparam logic [7:0]  OSC_STAB_SEL_RESET = 8'h04;     // longest wait after reset
    localparam int          STAB_SEL_LSB       = 0;         // select field low bit
    localparam int          STAB_SEL_W         = 3;         // select field width
    localparam logic [7:0]  STAB_SEL_MASK      = 8'h07;     // writable bits
    localparam logic [7:0]  STBY_CTRL_RESET    = 8'h00;     // control reset value
    localparam int          CNT_W              = 18;        // wait counter width
    // stabilisation exponents for codes 0..4
    localparam int          EXP_C0             = 12;
    localparam int          EXP_C1             = 14;
    localparam int          EXP_C2             = 15;
    localparam int          EXP_C3             = 16;
    localparam int          EXP_C4             = 17;
    // wake delays after halt release, in cpu clocks (the longer figure when vectoring)
    localparam logic [3:0]  WAKE_VECTOR_CLKS   = 4'h8;
    localparam logic [3:0]  WAKE_NEXT_CLKS     = 4'h2;
    // control register bit positions
    localparam int          CTRL_WT_SUB_BIT    = 0;  // watch timer counts subsystem clock
    localparam int          CTRL_T16_EXT_BIT   = 1;  // 16-bit timer counts external input
    localparam int          CTRL_SIO_EXT_BIT   = 2;  // serial clock supplied externally
    localparam int          CTRL_EXPAND_BIT    = 3;  // external expansion active

    typedef enum logic [4:0] {
        ST_RUN    = 5'h01,
        ST_HALT   = 5'h02,
        ST_STOP   = 5'h04,
        ST_STAB   = 5'h08,
        ST_WAKE   = 5'h10
    } stby_state_t;
endpackage

// >>> stby_regs_if.sv
// interface carrying register values from the register file to the sequencer
// assumes both ends sit on clk_in
`timescale 1ns/10ps
interface stby_regs_if;
    logic [2:0] stab_sel;     // stabilisation select code
    logic [7:0] ctrl;         // control bits
    modport regs (output stab_sel, output ctrl);
    modport core (input stab_sel, input ctrl);
endinterface

// >>> stby_regfile.sv
// register file for the standby controller on a plain strobe port
// assumes one-cycle strobes, read data in the following cycle
`timescale 1ns/10ps
module stby_regfile
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // register port
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [7:0]       rdata_out,
    // status from the sequencer
    input  wire logic [4:0]  state_in,
    // register values
    stby_regs_if.regs        regs
);
    logic [7:0] sel_ff, nxt_sel;    // stabilisation select
    logic [7:0] ctrl_ff, nxt_ctrl;  // control bits
    logic [7:0] rd_ff, nxt_rd;      // read data register

    // next-value logic: byte writes only, prohibited codes ignored
    always_comb
    begin
        nxt_sel  = sel_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rd   = 8'h00;
        if (wr_in && addr_in == standby_pkg::OSC_STAB_SEL_ADDR)
        begin
            // codes above 4 are prohibited, keep the old select
            if ((wdata_in & standby_pkg::STAB_SEL_MASK) <= standby_pkg::OSC_STAB_SEL_RESET) // [RQ6]
                nxt_sel = wdata_in & standby_pkg::STAB_SEL_MASK; // [RQ7]
        end
        if (wr_in && addr_in == standby_pkg::STBY_CTRL_ADDR)
            nxt_ctrl = wdata_in;
        if (rd_in)
        begin
            unique case (addr_in)
                standby_pkg::OSC_STAB_SEL_ADDR: nxt_rd = sel_ff;
                standby_pkg::STBY_CTRL_ADDR:    nxt_rd = ctrl_ff;
                standby_pkg::STBY_STATUS_ADDR:  nxt_rd = {3'h0, state_in};
                default:                        nxt_rd = 8'h00;  // unmapped reads zero
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sel_ff  <= standby_pkg::OSC_STAB_SEL_RESET; // [RQ7]
            ctrl_ff <= standby_pkg::STBY_CTRL_RESET;
            rd_ff   <= 8'h00;
        end
        else
        begin
            sel_ff  <= nxt_sel;
            ctrl_ff <= nxt_ctrl;
            rd_ff   <= nxt_rd;
        end
    end

    assign rdata_out     = rd_ff;
    assign regs.stab_sel = sel_ff[standby_pkg::STAB_SEL_LSB +: standby_pkg::STAB_SEL_W];
    assign regs.ctrl     = ctrl_ff;

    // a write of a legal code shows up on the next cycle
    a_sel_write_lands: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_in && addr_in == standby_pkg::OSC_STAB_SEL_ADDR && wdata_in == 8'h01)
        |=> regs.stab_sel == 3'h1) // [RQ7]
        else $error("select write lost");
endmodule // stby_regfile

// >>> cpu_irq_model.sv
// partner model: cpu decode, interrupt controller and main crystal start-up
// assumes the standby block samples every input on the rising edge of clk_in
`timescale 1ns/10ps
module cpu_irq_model
#(
    parameter int OSC_DLY = 300  // crystal start-up in clocks, plain default
)
(
    // clock and oscillator enable from the block
    input  wire logic clk_in,
    input  wire logic osc_en_in,
    // decode pulses and request levels
    output logic      halt_out,
    output logic      stop_out,
    output logic      sub_out,
    output logic      irq_out,
    output logic      ack_out,
    output logic      nmi_out,
    // crystal running
    output logic      osc_ok_out
);
    int osc_cnt;  // enabled clocks so far

    // quiet at time zero, crystal not yet running
    initial
    begin
        {halt_out, stop_out, sub_out, irq_out, ack_out, nmi_out, osc_ok_out} = 7'h00;
        osc_cnt = 0;
    end

    // start-up restarts whenever the enable drops, as a real crystal would
    always @(posedge clk_in)
    begin
        osc_cnt <= osc_en_in ? ((osc_cnt < OSC_DLY) ? osc_cnt + 1 : osc_cnt) : 0;
        osc_ok_out <= osc_en_in && (osc_cnt >= OSC_DLY);
    end

    // one-cycle decode pulse launched just after an edge
    task automatic instr(input logic h, input logic s);
        @(posedge clk_in);
        halt_out <= h;
        stop_out <= s;
        @(posedge clk_in);
        halt_out <= 1'b0;
        stop_out <= 1'b0;
    endtask

    // request and clock-source levels, held until the next call
    task automatic req(input logic i, input logic n, input logic a, input logic s);
        @(posedge clk_in);
        irq_out <= i;
        nmi_out <= n;
        ack_out <= a;
        sub_out <= s;
    endtask
endmodule  // cpu_irq_model

// >>> standby_halt_stop_control_bench.sv
// self-checking bench for the standby sequencer and its register port
// assumes cpu_irq_model stands in for cpu, interrupt controller and crystal
`timescale 1ns/10ps
module standby_halt_stop_control_bench;
    localparam int DLY = 300;                       // crystal start-up
    logic        clk, rst, wr, rd;                  // clock, reset, strobes
    logic [15:0] addr;                              // register address
    logic [7:0]  wdata, rdata, d;                   // write, read, result
    logic        halt, stop, sub, irq, ack, nmi;    // partner levels
    logic        osc_ok, osc_en, cpu_en, hold;      // clock side
    logic        res_v, res_n, rst_v, vec;          // resume pulses
    logic [5:0]  pins;                              // parked bus pins
    logic [2:0]  run;                               // peripheral run permissions
    logic [4:0]  st;                                // one-hot state
    int          lat, error_cnt, num_checks;        // latency, tallies

    standby_halt_stop_control DUT
    (
        .clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .halt_exec_in(halt), .stop_exec_in(stop), .on_subclock_in(sub),
        .irq_unmasked_in(irq), .irq_ack_enable_in(ack), .nmi_in(nmi), .main_osc_started_in(osc_ok),
        .main_osc_enable_out(osc_en), .cpu_clk_enable_out(cpu_en), .resume_vector_out(res_v),
        .resume_next_out(res_n), .reset_vector_out(rst_v), .hold_state_out(hold),
        .watch_timer_run_out(run[2]), .timer16_run_out(run[1]), .serial_run_out(run[0]),
        .bus_hold_out(pins[5]), .muxed_addr_data_lines_oe_out(pins[4]), .address_strobe_out(pins[3]),
        .rd_strobe_n_out(pins[2]), .wr_strobe_n_out(pins[1]), .wait_pin_oe_out(pins[0]),
        .state_out(st)
    );
    cpu_irq_model #(.OSC_DLY(DLY)) u_cpu
    (
        .clk_in(clk), .osc_en_in(osc_en), .halt_out(halt), .stop_out(stop), .sub_out(sub),
        .irq_out(irq), .ack_out(ack), .nmi_out(nmi), .osc_ok_out(osc_ok)
    );

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare and tally; four-state equality so unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // single-cycle write strobe
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // single-cycle read strobe, data taken in the following cycle only
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // raise a release request, count clocks until a resume pulse shows
    task automatic wake(input logic i, input logic n, input logic a, input logic s);
        u_cpu.req(i, n, a, s);
        lat = 0;
        do
        begin
            @(posedge clk);
            #1;
            lat++;
        end
        while ((res_v | res_n) !== 1'b1 && lat < 9000);
        vec = res_v;
        u_cpu.req(1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    // main sequence
    initial
    begin
        {rst, wr, rd, addr, wdata} = {1'b1, 26'h0};
        error_cnt = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(st, standby_pkg::ST_STAB);
        lat = 0;
        while (rst_v !== 1'b1 && lat < 140000)
        begin
            @(posedge clk);
            #1;
            lat++;
        end
        check(lat >= 131072 + DLY && lat < 140000, 1'b1);
        reg_rd(standby_pkg::OSC_STAB_SEL_ADDR, d);
        check(d, standby_pkg::OSC_STAB_SEL_RESET);
        // every code, prohibited ones must leave the last legal value
        for (int c = 0; c < 8; c++)
        begin
            reg_wr(standby_pkg::OSC_STAB_SEL_ADDR, 8'(c));
            reg_rd(standby_pkg::OSC_STAB_SEL_ADDR, d);
            check(d, (c < 5) ? c : 4);
        end
        reg_wr(standby_pkg::OSC_STAB_SEL_ADDR, 8'hF8);
        reg_rd(standby_pkg::OSC_STAB_SEL_ADDR, d);
        check(d, 8'h00);
        reg_rd(16'h1234, d);
        check(d, 8'h00);
        // halt on both clocks, released by irq with and without ack, and by nmi
        for (int k = 0; k < 4; k++)
        begin
            // expansion on; peripheral clock options only in the last two passes
            reg_wr(standby_pkg::STBY_CTRL_ADDR, (k < 2) ? 8'h08 : 8'h0F);
            u_cpu.req(1'b0, 1'b0, k == 1, k[0]);
            u_cpu.instr(1'b1, 1'b0);
            #1;
            check(st, standby_pkg::ST_HALT);
            check({cpu_en, osc_en, hold}, 3'b011);
            check(pins, 6'b100110);
            check(run, (k >= 2) ? 3'b111 : (k[0] ? 3'b010 : 3'b101));
            reg_rd(standby_pkg::OSC_STAB_SEL_ADDR, d);
            check(d, 8'h00);
            wake(k != 2, k == 2, k == 1, k[0]);
            check(vec, k == 1 || k == 2);
            // count includes the edge that takes the request; the pulse is registered after the wait
            check(lat, 32'(vec ? standby_pkg::WAKE_VECTOR_CLKS : standby_pkg::WAKE_NEXT_CLKS) + 1);
        end
        // stop, then irq release after crystal start plus the code-0 wait
        u_cpu.instr(1'b0, 1'b1);
        #1;
        check({st, osc_en}, {standby_pkg::ST_STOP, 1'b0});
        wake(1'b1, 1'b0, 1'b1, 1'b0);
        check(vec, 1'b1);
        check(lat >= DLY + 4097 && lat < DLY + 4130, 1'b1);
        // stop refused on the subsystem clock; halt wins there when both decode
        u_cpu.req(1'b0, 1'b0, 1'b0, 1'b1);
        u_cpu.instr(1'b0, 1'b1);
        #1;
        check(st, standby_pkg::ST_RUN);
        u_cpu.instr(1'b1, 1'b1);
        #1;
        check({st, osc_en}, {standby_pkg::ST_HALT, 1'b1});
        wake(1'b1, 1'b0, 1'b0, 1'b1);
        check(vec, 1'b0);
        // stop with a request already pending falls straight to the wait
        u_cpu.req(1'b1, 1'b0, 1'b0, 1'b0);
        u_cpu.instr(1'b0, 1'b1);
        #1;
        check({st, osc_en}, {standby_pkg::ST_STAB, 1'b1});
        wake(1'b1, 1'b0, 1'b0, 1'b0);
        check(lat >= 4090 && lat < 4110 && vec === 1'b0, 1'b1);
        // reset in the middle of halt
        u_cpu.instr(1'b1, 1'b0);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        check({st, cpu_en}, {standby_pkg::ST_STAB, 1'b0});
        reg_rd(standby_pkg::OSC_STAB_SEL_ADDR, d);
        check(d, standby_pkg::OSC_STAB_SEL_RESET);
        final_report();
    end

    // watchdog: the run needs about 140k clocks, allow 200k
    initial
    begin
        #2000000;
        error_cnt++;
        final_report();
    end
endmodule  // standby_halt_stop_control_bench
